// >>> hdl/lrr_buf.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer: output register plus one spare
module lrr_buf #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic empty
);
	logic spare_valid_q;
	logic [WIDTH-1:0] spare_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_q;
	wire in_take = in_valid && !spare_valid_q;
	wire out_free = out_ready || !out_valid_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_valid_q <= 1'b0;
			out_q <= '0;
			spare_valid_q <= 1'b0;
			spare_q <= '0;
		end else if (out_free) begin
			out_valid_q <= spare_valid_q || in_take;
			out_q <= spare_valid_q ? spare_q : in_data;
			spare_valid_q <= 1'b0;
		end else if (in_take) begin
			spare_valid_q <= 1'b1;
			spare_q <= in_data;
		end
	end

	assign in_ready = !spare_valid_q;
	assign out_valid = out_valid_q;
	assign out_data = out_q;
	assign empty = !out_valid_q && !spare_valid_q;
endmodule
`default_nettype wire

// >>> hdl/lrr_cmd.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - run packet is seven bytes: length, sum, code 0x22, four address bytes.
// - run address arrives most significant byte first.
// - a valid run packet makes the device execute from the given address.
// - acknowledge for run leaves the device before control transfers.
// - restart packet is three bytes: length, sum equal to code, code 0x25.
// - acknowledge for restart leaves the device before the software reset.
// - restart gives a full reset; run does not reset anything.
// - acknowledge is 0xcc, negative acknowledge 0x33; leading zeros ignored.
// - sum byte is the byte-wide sum of data bytes only.
// - first non-zero byte gives total length including length and sum.
module lrr_cmd
	import lrr_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic run_go,
	output logic [31:0] run_addr,
	output logic restart_go
);
	lrr_state_t state_q, state_d;
	logic [7:0] len_q;
	logic [7:0] cnt_q;
	logic [7:0] sum_q;
	logic [7:0] acc_q;
	logic [7:0] cmd_q;
	logic [31:0] addr_q;
	logic ack_q;
	logic rx_ready_q;
	logic run_go_q;
	logic restart_go_q;
	logic [31:0] run_addr_q;
	logic buf_in_ready;
	logic buf_empty;

	wire rx_take = rx_valid && rx_ready_q;
	wire at_len = cnt_q == LRR_IDX_LEN;
	wire at_sum = cnt_q == LRR_IDX_SUM;
	wire at_cmd = cnt_q == LRR_IDX_CMD;
	wire in_data = cnt_q >= LRR_IDX_CMD;
	wire in_addr = in_data && !at_cmd && cnt_q <= LRR_IDX_ADDR_LAST;
	wire skip_zero = at_len && rx_data == LRR_ZERO;
	wire [7:0] cnt_inc = cnt_q + LRR_ONE;
	wire last_byte = at_len ? (rx_data == LRR_ONE) : (cnt_inc == len_q);
	wire [7:0] acc_n = in_data ? acc_q + rx_data : acc_q;
	wire [7:0] cmd_n = at_cmd ? rx_data : cmd_q;
	wire is_run = cmd_n == LRR_CMD_RUN && len_q == LRR_LEN_RUN;
	wire is_rst = cmd_n == LRR_CMD_RESTART && len_q == LRR_LEN_RESTART;
	// only a matching sum of a known packet is acknowledged
	wire good_pkt = !at_len && (is_run || is_rst) && acc_n == sum_q;
	wire done_pkt = rx_take && !skip_zero && last_byte;
	wire resp_push = state_q == LRR_ST_RESP;
	wire [7:0] resp_byte = ack_q ? LRR_ACK : LRR_NAK;
	wire ack_run = cmd_q == LRR_CMD_RUN;
	wire act_now = state_q == LRR_ST_WAIT && buf_empty;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LRR_ST_RX: begin
				if (done_pkt) begin
					state_d = LRR_ST_RESP;
				end
			end
			LRR_ST_RESP: begin
				if (buf_in_ready) begin
					state_d = ack_q ? LRR_ST_WAIT : LRR_ST_RX;
				end
			end
			LRR_ST_WAIT: begin
				if (buf_empty) begin
					state_d = LRR_ST_RX;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= LRR_ST_RX;
			rx_ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rx_ready_q <= state_d == LRR_ST_RX && !done_pkt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			len_q <= LRR_ZERO;
			cnt_q <= LRR_ZERO;
			sum_q <= LRR_ZERO;
			acc_q <= LRR_ZERO;
			cmd_q <= LRR_ZERO;
		end else if (rx_take && !skip_zero) begin
			len_q <= at_len ? rx_data : len_q;
			cnt_q <= last_byte ? LRR_ZERO : cnt_inc;
			sum_q <= at_sum ? rx_data : sum_q;
			acc_q <= last_byte ? LRR_ZERO : acc_n;
			cmd_q <= cmd_n;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= LRR_ADDR_RESET;
		end else if (rx_take && in_addr) begin
			addr_q <= {addr_q[23:0], rx_data};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
		end else if (done_pkt) begin
			ack_q <= good_pkt;
		end
	end

	// act only after answer byte has left
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_go_q <= 1'b0;
			restart_go_q <= 1'b0;
			run_addr_q <= LRR_ADDR_RESET;
		end else begin
			run_go_q <= act_now && ack_run;
			restart_go_q <= act_now && !ack_run;
			if (act_now && ack_run) begin
				run_addr_q <= addr_q;
			end
		end
	end

	lrr_buf #(
		.WIDTH(8)
	) u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(resp_push),
		.in_data(resp_byte),
		.in_ready(buf_in_ready),
		.out_valid(tx_valid),
		.out_data(tx_data),
		.out_ready(tx_ready),
		.empty(buf_empty)
	);

	assign rx_ready = rx_ready_q;
	assign run_go = run_go_q;
	assign run_addr = run_addr_q;
	assign restart_go = restart_go_q;

	ack_before_run_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		run_go_q |-> $past(buf_empty) && $past(state_q == LRR_ST_WAIT))
		else $error("run issued before acknowledge left");

	ack_before_restart_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		restart_go_q |-> $past(buf_empty) && !tx_valid)
		else $error("restart issued before acknowledge left");

	run_follows_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(act_now && ack_run) |=> run_go_q && run_addr_q == $past(addr_q))
		else $error("run not issued with captured address");

	resp_value_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(resp_push |-> (resp_byte == 8'hcc) == ack_q)
		and (tx_valid |-> tx_data == 8'hcc || tx_data == 8'h33))
		else $error("answer byte not ack or nak");

	nak_no_action_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(resp_push && !ack_q && buf_in_ready) |=>
			(!run_go_q && !restart_go_q)[*3])
		else $error("action after negative acknowledge");

	sum_match_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(resp_push && ack_q) |-> sum_q == (cmd_q == 8'h25 ? cmd_q
			: cmd_q + addr_q[31:24] + addr_q[23:16] + addr_q[15:8]
			+ addr_q[7:0]))
		else $error("acknowledge with bad sum");

	zero_skip_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(rx_take && skip_zero) |=> cnt_q == 8'h00 && $stable(len_q))
		else $error("leading zero not ignored");

	run_len_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		run_go_q |-> len_q == 8'h07 && cmd_q == 8'h22)
		else $error("run from wrong packet");

	restart_len_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		restart_go_q |-> len_q == 8'h03 && cmd_q == 8'h25)
		else $error("restart from wrong packet");

	one_action_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		!(run_go_q && restart_go_q))
		else $error("run and restart together");
endmodule
`default_nettype wire

// >>> hdl/lrr_pkg.sv
package lrr_pkg;
	localparam logic [7:0] LRR_ACK = 8'hcc;
	localparam logic [7:0] LRR_NAK = 8'h33;
	localparam logic [7:0] LRR_CMD_RUN = 8'h22;
	localparam logic [7:0] LRR_CMD_RESTART = 8'h25;
	localparam logic [7:0] LRR_LEN_RUN = 8'h07;
	localparam logic [7:0] LRR_LEN_RESTART = 8'h03;
	localparam logic [7:0] LRR_IDX_LEN = 8'h00;
	localparam logic [7:0] LRR_IDX_SUM = 8'h01;
	localparam logic [7:0] LRR_IDX_CMD = 8'h02;
	localparam logic [7:0] LRR_IDX_ADDR_LAST = 8'h06;
	localparam logic [7:0] LRR_ZERO = 8'h00;
	localparam logic [7:0] LRR_ONE = 8'h01;
	localparam logic [31:0] LRR_ADDR_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		LRR_ST_RX,
		LRR_ST_RESP,
		LRR_ST_WAIT
	} lrr_state_t;
endpackage

// >>> testbench/lrr_host.sv
`timescale 1ns/1ps
`default_nettype none
module lrr_host (
	input wire logic clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic [7:0] got[$];
	int stall = 0;
	int wait_n = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5a;
		tx_ready = 1'b0;
	end
	// bytes in order, each held until taken or for at most 50 cycles
	task automatic send(input logic [7:0] b[$]);
		int n;
		@(posedge clk);
		foreach (b[i]) begin
			n = 0;
			#1 rx_valid = 1'b1;
			rx_data = b[i];
			do begin
				@(posedge clk);
				n++;
			end while (!rx_ready && n < 50);
		end
		#1 rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
	// answer byte collected, after an optional stall
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			wait_n = 0;
		end else if (tx_valid) begin
			wait_n++;
		end
		#1 tx_ready = (wait_n >= stall);
	end
endmodule
`default_nettype wire

// >>> testbench/test_loader_run_reset_commands.sv
`timescale 1ns/1ps
`default_nettype none
module test_loader_run_reset_commands
	import lrr_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, run_go, restart_go;
	logic [7:0] rx_data, tx_data;
	logic [31:0] run_addr;
	int failures = 0;
	int checks = 0;
	int runs = 0;
	int rsts = 0;
	always #2 clk = ~clk;
	lrr_cmd DUT (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .run_go(run_go),
		.run_addr(run_addr), .restart_go(restart_go));
	lrr_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready));
	always @(posedge clk) begin
		if (run_go === 1'b1) runs++;
		if (restart_go === 1'b1) rsts++;
	end
	task chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] sum8(input logic [7:0] b[$]);
		sum8 = 8'h00;
		foreach (b[i]) sum8 += b[i];
	endfunction
	task automatic pkt(input logic [7:0] b[$], input logic [7:0] ans,
		input int er, input int es, input logic [31:0] ea);
		int n, r0, s0, k;
		n = host.got.size();
		r0 = runs;
		s0 = rsts;
		k = 0;
		host.send(b);
		while (host.got.size() == n && k < 100) begin
			@(posedge clk);
			k++;
		end
		chk("answer", host.got.size() > n ? host.got[n] : 8'hxx, ans);
		chk("pulse before answer", 32'(runs - r0 + rsts - s0), 0);
		repeat (6) @(posedge clk);
		chk("run pulses", 32'(runs - r0), 32'(er));
		chk("restart pulses", 32'(rsts - s0), 32'(es));
		if (er != 0) chk("run addr", run_addr, ea);
	endtask
	task automatic run_cmd(input logic [31:0] a, input logic [7:0] lead,
		input logic [7:0] bad, input logic [7:0] ans, input int er);
		logic [7:0] d[$];
		logic [7:0] p[$];
		d = {LRR_CMD_RUN, a[31:24], a[23:16], a[15:8], a[7:0]};
		p = {LRR_LEN_RUN, sum8(d) ^ bad, d};
		if (lead != 8'h00) p = {8'h00, 8'h00, p};
		pkt(p, ans, er, 0, a);
	endtask
	task t_run_lead_stall;
		host.stall = 3;
		run_cmd(32'h1234_5678, 8'h01, 8'h00, LRR_ACK, 1);
		host.stall = 0;
	endtask
	task t_run_bad_sum;
		run_cmd(32'h0000_2000, 8'h00, 8'h01, LRR_NAK, 0);
	endtask
	task t_restart;
		host.stall = 2;
		pkt('{8'h03, 8'h25, 8'h25}, LRR_ACK, 0, 1, 32'h0);
		host.stall = 0;
	endtask
	task t_bad_lengths;
		pkt('{8'h03, 8'h22, 8'h22}, LRR_NAK, 0, 0, 32'h0);
		pkt('{8'h01}, LRR_NAK, 0, 0, 32'h0);
	endtask
	task t_run_top;
		run_cmd(32'hffff_fffc, 8'h00, 8'h00, LRR_ACK, 1);
	endtask
	task t_reset_mid;
		host.send('{8'h07, 8'h12, 8'h22});
		@(posedge clk);
		#1 reset_n = 1'b0;
		#1 chk("reset rx_ready", rx_ready, 0);
		chk("reset tx_valid", tx_valid, 0);
		chk("reset run_addr", run_addr, LRR_ADDR_RESET);
		chk("reset run_go", run_go, 0);
		chk("reset restart_go", restart_go, 0);
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		pkt('{8'h03, 8'h25, 8'h25}, LRR_ACK, 0, 1, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		t_run_lead_stall();
		t_run_bad_sum();
		t_restart();
		t_bad_lengths();
		t_run_top();
		t_reset_mid();
		conclude();
	end
	initial begin
		#20000;
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
